// ### hw/mspsel_pkg.sv
// Package of constants for the multi-speed preset selector
package mspsel_pkg;
   localparam int FREQ_W = 16;
   localparam int NUM_PRESETS = 16;
   localparam int NUM_TERMS = 5;
   localparam int SEL_W = 4;
   // Register byte offsets
   localparam logic [11:0] CTRL_OFF = 12'h000;
   localparam logic [11:0] STATUS_OFF = 12'h004;
   localparam logic [11:0] LIVE_OFF = 12'h008;
   localparam logic [11:0] MAXF_OFF = 12'h00c;
   localparam logic [11:0] TFUNC_OFF = 12'h010;
   localparam logic [11:0] STORE_OFF = 12'h014;
   localparam logic [11:0] MON_OFF = 12'h018;
   localparam logic [11:0] TFUNC5_OFF = 12'h01c;
   localparam logic [11:0] PRESET_OFF = 12'h100;
   // Function codes for speed-select bits 0..3, and the source code that selects the presets
   localparam logic [7:0] FUNCTION_VIEW_KEY_SEL_BIT0 = 8'h02;
   localparam logic [7:0] FUNCTION_VIEW_KEY_SEL_BIT3 = 8'h05;
   localparam logic [7:0] SRC_PRESET = 8'h02;
   // Field positions
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_SRC_LSB = 8;
   localparam int STORE_DIRECT_BIT = 0;
   localparam int STORE_LIVE_BIT = 1;
   localparam int STORE_IDX_LSB = 4;
   // Reset values
   localparam logic [7:0] SRC_RESET = 8'h00;
   localparam logic [7:0] TFUNC_RESET = 8'h00;
   localparam logic [15:0] MAXF_RESET = 16'h1388;
   localparam logic [15:0] FREQ_RESET = 16'h0000;
endpackage

// ### hw/mspsel_top.sv
// Multi-speed preset selector with AHB-Lite register access
`timescale 1ns/1ps
module mspsel_top (
   input wire logic hclk, // 200 MHz clock
   input wire logic hresetn, // Async reset, active low
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Byte address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write when high
   input wire logic [2:0] hsize, // Transfer size
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready, // Bus ready
   output logic [31:0] hrdata, // Read data
   output logic hreadyout, // Slave ready
   output logic hresp, // Always OKAY
   input wire logic [4:0] term_in, // Logic input terminals, polarity resolved
   input wire logic [15:0] output_freq_in, // Present output frequency from ramp
   output logic [15:0] target_freq, // Running target frequency
   output logic preset_active // Presets drive the target
);
   localparam int FW = mspsel_pkg::FREQ_W;

   logic [4:0] term_meta_reg;
   logic [4:0] term_sync_reg;
   logic [7:0] tfunc_reg [mspsel_pkg::NUM_TERMS];
   logic [FW-1:0] preset_reg [mspsel_pkg::NUM_PRESETS];
   logic [FW-1:0] live_reg;
   logic [FW-1:0] maxf_reg;
   logic [FW-1:0] mon_reg;
   logic [FW-1:0] target_reg;
   logic [7:0] src_reg;
   logic run_reg;
   logic [3:0] sel_reg;
   logic [31:0] hrdata_reg;
   logic wr_pend_reg;
   logic [11:0] wr_addr_reg;

   // Address phase capture
   wire logic ap_valid = hsel && hready && htrans[1];
   wire logic [11:0] wa = wr_addr_reg;
   wire logic wr_ctrl = wr_pend_reg && (wa == mspsel_pkg::CTRL_OFF);
   wire logic wr_live = wr_pend_reg && (wa == mspsel_pkg::LIVE_OFF);
   wire logic wr_maxf = wr_pend_reg && (wa == mspsel_pkg::MAXF_OFF);
   wire logic wr_tfunc = wr_pend_reg && (wa == mspsel_pkg::TFUNC_OFF);
   wire logic wr_store = wr_pend_reg && (wa == mspsel_pkg::STORE_OFF);
   wire logic wr_tfunc5 = wr_pend_reg && (wa == mspsel_pkg::TFUNC5_OFF);
   wire logic [3:0] st_idx = hwdata[mspsel_pkg::STORE_IDX_LSB +: 4];
   wire logic st_direct = wr_store && hwdata[mspsel_pkg::STORE_DIRECT_BIT];
   wire logic st_live = wr_store && hwdata[mspsel_pkg::STORE_LIVE_BIT];
   // Stores are refused while running so the active table never shifts
   wire logic store_ok = !run_reg;

   // Select code decode: each bit is the OR of terminals assigned its function
   logic [3:0] sel_next;
   genvar b;
   generate
      for (b = 0; b < mspsel_pkg::SEL_W; b++) begin : g_bit
         logic [4:0] hit;
         genvar t;
         for (t = 0; t < mspsel_pkg::NUM_TERMS; t++) begin : g_term
            // Only five terminals exist, so assignment is limited to them
            assign hit[t] = term_sync_reg[t] &&
               (tfunc_reg[t] == mspsel_pkg::FUNCTION_VIEW_KEY_SEL_BIT0 + 8'(b));
            map_hit_a: assert property (@(posedge hclk) disable iff (!hresetn)
               term_sync_reg[t] && tfunc_reg[t] == mspsel_pkg::FUNCTION_VIEW_KEY_SEL_BIT0 + 8'(b) |=> sel_reg[b])
               else $error("assigned terminal not decoded");
         end
         assign sel_next[b] = |hit;
      end
   endgenerate

   wire logic src_is_preset = (src_reg == mspsel_pkg::SRC_PRESET);
   wire logic [FW-1:0] sel_freq = preset_reg[sel_reg];
   // Clamping rather than refusing keeps a preset target at or below maxf_reg; the live setting passes unclamped
   wire logic [FW-1:0] lim_freq = (sel_freq > maxf_reg) ? maxf_reg : sel_freq;
   wire logic [FW-1:0] tgt_next = src_is_preset ? lim_freq : live_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         term_meta_reg <= 5'h00;
         term_sync_reg <= 5'h00;
      end else begin
         term_meta_reg <= term_in;
         term_sync_reg <= term_meta_reg;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_reg <= 4'h0;
         target_reg <= mspsel_pkg::FREQ_RESET;
         mon_reg <= mspsel_pkg::FREQ_RESET;
      end else begin
         sel_reg <= sel_next;
         target_reg <= tgt_next;
         mon_reg <= output_freq_in;
      end
   end

   // Bus write data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 12'h000;
      end else begin
         wr_pend_reg <= ap_valid && hwrite;
         wr_addr_reg <= haddr[11:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_reg <= 1'b0;
         src_reg <= mspsel_pkg::SRC_RESET;
         maxf_reg <= mspsel_pkg::MAXF_RESET;
      end else begin
         if (wr_ctrl) begin
            run_reg <= hwdata[mspsel_pkg::CTRL_RUN_BIT];
            src_reg <= hwdata[mspsel_pkg::CTRL_SRC_LSB +: 8];
         end
         if (wr_maxf) begin
            maxf_reg <= hwdata[FW-1:0];
         end
      end
   end

   // Live setting: edited by software, copied into the selected entry on a live store
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         live_reg <= mspsel_pkg::FREQ_RESET;
      end else if (wr_live) begin
         live_reg <= hwdata[FW-1:0];
      end
   end

   genvar p;
   generate
      for (p = 0; p < mspsel_pkg::NUM_TERMS; p++) begin : g_tfunc
         wire logic f_we;
         wire logic [7:0] f_data;
         if (p < 4) begin : g_word
            assign f_we = wr_tfunc;
            assign f_data = hwdata[p*8 +: 8];
         end else begin : g_fifth
            // A word holds four function bytes, so terminal five has a word of its own
            assign f_we = wr_tfunc5;
            assign f_data = hwdata[7:0];
         end
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               tfunc_reg[p] <= mspsel_pkg::TFUNC_RESET;
            end else if (f_we) begin
               tfunc_reg[p] <= f_data;
            end
         end
      end
      for (p = 0; p < mspsel_pkg::NUM_PRESETS; p++) begin : g_preset
         // Direct edits carry the value in hwdata[31:16]; a store commits it
         wire logic hit_live = st_live && store_ok && (sel_reg == 4'(p));
         wire logic hit_dir = st_direct && store_ok && (st_idx == 4'(p));
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               preset_reg[p] <= mspsel_pkg::FREQ_RESET;
            end else if (hit_live) begin
               preset_reg[p] <= live_reg;
            end else if (hit_dir) begin
               preset_reg[p] <= hwdata[31:16];
            end
         end
         // A running drive must never see its table move under it
         run_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
            run_reg |=> $stable(preset_reg[p]))
            else $error("preset entry changed while running");
         dir_commit_a: assert property (@(posedge hclk) disable iff (!hresetn)
            st_direct && !st_live && !run_reg && st_idx == 4'(p)
            |=> preset_reg[p] == $past(hwdata[31:16]))
            else $error("direct store missed its entry");
         live_commit_a: assert property (@(posedge hclk) disable iff (!hresetn)
            hit_live |=> preset_reg[p] == $past(live_reg))
            else $error("live store missed its entry");
      end
   endgenerate

   // Read decode
   wire logic [11:0] ra = haddr[11:0];
   wire logic rd_preset = (ra[11:8] == 4'h1) && (ra[7:6] == 2'b00) && (ra[1:0] == 2'b00);
   logic [31:0] rd_next;
   always_comb begin
      rd_next = 32'h0000_0000;
      if (ra == mspsel_pkg::CTRL_OFF) begin
         rd_next = {16'h0000, src_reg, 7'h00, run_reg};
      end else if (ra == mspsel_pkg::STATUS_OFF) begin
         rd_next = {26'h0, src_is_preset, 1'b0, sel_reg};
      end else if (ra == mspsel_pkg::LIVE_OFF) begin
         rd_next = {16'h0000, live_reg};
      end else if (ra == mspsel_pkg::MAXF_OFF) begin
         rd_next = {16'h0000, maxf_reg};
      end else if (ra == mspsel_pkg::TFUNC_OFF) begin
         rd_next = {tfunc_reg[3], tfunc_reg[2], tfunc_reg[1], tfunc_reg[0]};
      end else if (ra == mspsel_pkg::TFUNC5_OFF) begin
         rd_next = {24'h000000, tfunc_reg[4]};
      end else if (ra == mspsel_pkg::MON_OFF) begin
         rd_next = {16'h0000, mon_reg};
      end else if (rd_preset) begin
         rd_next = {16'h0000, preset_reg[ra[5:2]]};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (ap_valid && !hwrite) begin
         hrdata_reg <= rd_next;
      end
   end

   assign hrdata = hrdata_reg;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign target_freq = target_reg;
   assign preset_active = src_is_preset;

   // Checks
   no_store_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
      run_reg && !wr_ctrl |=> $stable(preset_reg[0]) || !$past(run_reg))
      else $error("preset changed while running");
   live_store_a: assert property (@(posedge hclk) disable iff (!hresetn)
      st_live && !run_reg && sel_reg == 4'h3 |=> preset_reg[3] == $past(live_reg))
      else $error("live store missed selected entry");
   sel_sync_a: assert property (@(posedge hclk) disable iff (!hresetn)
      tfunc_reg[0] == mspsel_pkg::FUNCTION_VIEW_KEY_SEL_BIT0 && tfunc_reg[1] == 8'h00 &&
      tfunc_reg[2] == 8'h00 && tfunc_reg[3] == 8'h00 && tfunc_reg[4] == 8'h00
      && $stable(tfunc_reg[0]) |=> sel_reg == {3'b000, $past(term_sync_reg[0])})
      else $error("select bit 0 decode wrong");
   bit3_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
      tfunc_reg[4] == mspsel_pkg::FUNCTION_VIEW_KEY_SEL_BIT3 && term_sync_reg[4] |=> sel_reg[3])
      else $error("bit 3 function not decoded");
   target_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
      src_is_preset && sel_freq <= maxf_reg |=> target_freq == $past(sel_freq))
      else $error("target not following selected preset");
   src_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !src_is_preset |=> target_freq == $past(live_reg))
      else $error("preset used without preset source");
   max_clamp_a: assert property (@(posedge hclk) disable iff (!hresetn)
      src_is_preset |=> target_freq <= $past(maxf_reg))
      else $error("target above maximum");
   mon_track_a: assert property (@(posedge hclk) disable iff (!hresetn)
      1'b1 |=> mon_reg == $past(output_freq_in))
      else $error("monitor not tracking output");
   direct_store_a: assert property (@(posedge hclk) disable iff (!hresetn)
      st_direct && !st_live && !run_reg && st_idx == 4'h5
      |=> preset_reg[5] == $past(hwdata[31:16]))
      else $error("direct preset store missed");

   // Decode and target path
   zero_code_a: assert property (@(posedge hclk) disable iff (!hresetn)
      src_is_preset && sel_reg == 4'h0 && preset_reg[0] <= maxf_reg
      |=> target_freq == $past(preset_reg[0]))
      else $error("code zero not using entry zero");

   clamp_eq_a: assert property (@(posedge hclk) disable iff (!hresetn)
      src_is_preset && sel_freq > maxf_reg |=> target_freq == $past(maxf_reg))
      else $error("preset above maximum not held at maximum");

   retarget_a: assert property (@(posedge hclk) disable iff (!hresetn)
      src_is_preset && $changed(sel_reg) && sel_freq <= maxf_reg
      |=> target_freq == $past(sel_freq))
      else $error("select change did not retarget");

   // Two stages keep a changing contact out of the decode
   sync_depth_a: assert property (@(posedge hclk) disable iff (!hresetn)
      1'b1 |=> ##1 term_sync_reg == $past(term_in, 2))
      else $error("terminal synchroniser depth wrong");

   unassigned_a: assert property (@(posedge hclk) disable iff (!hresetn)
      tfunc_reg[0] == 8'h00 && tfunc_reg[1] == 8'h00 && tfunc_reg[2] == 8'h00
      && tfunc_reg[3] == 8'h00 && tfunc_reg[4] == 8'h00 |=> sel_reg == 4'h0)
      else $error("unassigned bits not read as zero");

   // Bus-side checks
   status_rd_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ap_valid && !hwrite && ra == mspsel_pkg::STATUS_OFF
      |=> hrdata[3:0] == $past(sel_reg))
      else $error("status select code wrong");

   mon_rd_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ap_valid && !hwrite && ra == mspsel_pkg::MON_OFF
      |=> hrdata[15:0] == $past(mon_reg))
      else $error("monitor readback wrong");

   rd_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !(ap_valid && !hwrite) |=> $stable(hrdata))
      else $error("read data moved without a read");

   live_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_live |=> live_reg == $past(hwdata[15:0]))
      else $error("live setting write lost");

   live_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !wr_live |=> $stable(live_reg))
      else $error("live setting moved without a write");

   src_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_ctrl |=> preset_active == ($past(hwdata[15:8]) == mspsel_pkg::SRC_PRESET))
      else $error("source select not applied");

   run_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_ctrl |=> run_reg == $past(hwdata[0]))
      else $error("run command not applied");

   maxf_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_maxf |=> maxf_reg == $past(hwdata[15:0]))
      else $error("maximum frequency write lost");

   tfunc_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_tfunc |=> tfunc_reg[0] == $past(hwdata[7:0]))
      else $error("terminal one function write lost");

   tfunc5_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_tfunc5 |=> tfunc_reg[4] == $past(hwdata[7:0]))
      else $error("terminal five function write lost");
endmodule // mspsel_top

// ### bench/mspsel_switches.sv
// Switch bank model driving the drive's logic input terminals
`timescale 1ns/1ps
module mspsel_switches (
   input wire logic hclk, // Bench clock
   input wire logic [4:0] want, // Requested contact pattern
   output logic [4:0] term_in // Terminal levels, 1 = active
);
   initial term_in = 5'h00;
   // Contacts move off the edge; the device must synchronise them itself
   always @(posedge hclk) term_in <= want;
endmodule // mspsel_switches

// ### bench/tb_top.sv
// Self-checking bench for the multi-speed preset selector
`timescale 1ns/1ps
module tb_top;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, preset_active;
   logic [31:0] haddr, hwdata, hrdata, rv;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [15:0] output_freq_in, target_freq;
   logic [4:0] want, term_in;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;

   mspsel_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .term_in(term_in),
      .output_freq_in(output_freq_in), .target_freq(target_freq),
      .preset_active(preset_active));
   mspsel_switches sw_u (.hclk(hclk), .want(want), .term_in(term_in));

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   // One single AHB-Lite transfer; read data lands in rv
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      hsel <= 1'b1;
      hwrite <= wr;
      haddr <= {20'h00000, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rv = hrdata;
   endtask

   // Terminal one carries bit 3, two bit 0, three bit 2, four bit 1
   function automatic logic [4:0] pins(input logic [3:0] c);
      return {1'b0, c[1], c[2], c[0], c[3]};
   endfunction

   function automatic logic [15:0] fv(input int n);
      return 16'h0100 + 16'(n * 256);
   endfunction

   task automatic t_reset();
      chk(32'h0, {15'h0, preset_active, target_freq});
      xfer(0, mspsel_pkg::CTRL_OFF, 32'h0);
      chk(32'h0, rv);
      xfer(0, mspsel_pkg::MAXF_OFF, 32'h0);
      chk(32'h1388, rv);
      xfer(0, mspsel_pkg::TFUNC_OFF, 32'h0);
      chk(32'h0, rv);
      xfer(0, mspsel_pkg::TFUNC5_OFF, 32'h0);
      chk(32'h0, rv);
      $display("reset test done");
   endtask

   task automatic t_presets();
      for (int n = 0; n < 16; n++) begin
         xfer(1, mspsel_pkg::STORE_OFF, {fv(n), 8'h00, 4'(n), 4'h1});
      end
      for (int n = 0; n < 16; n++) begin
         xfer(0, mspsel_pkg::PRESET_OFF + 12'(4 * n), 32'h0);
         chk({16'h0, fv(n)}, rv);
      end
      $display("preset test done");
   endtask

   task automatic t_select();
      xfer(1, mspsel_pkg::TFUNC_OFF, 32'h03040205);
      xfer(1, mspsel_pkg::CTRL_OFF, 32'h00000201);
      for (int c = 0; c < 16; c++) begin
         want <= pins(4'(c));
         output_freq_in <= 16'h0aa0 + 16'(c);
         repeat (6) @(posedge hclk);
         chk({16'h0, fv(c)}, {16'h0, target_freq});
         xfer(0, mspsel_pkg::STATUS_OFF, 32'h0);
         chk(32'h20 | 32'(c), rv & 32'h2f);
         xfer(0, mspsel_pkg::MON_OFF, 32'h0);
         chk(32'h0aa0 + 32'(c), rv);
      end
      $display("select test done");
   endtask

   task automatic t_subset();
      xfer(1, mspsel_pkg::TFUNC_OFF, 32'h00000002);
      want <= 5'h1f;
      repeat (6) @(posedge hclk);
      chk({16'h0, fv(1)}, {16'h0, target_freq});
      xfer(1, mspsel_pkg::TFUNC_OFF, 32'h00000302);
      repeat (6) @(posedge hclk);
      chk({16'h0, fv(3)}, {16'h0, target_freq});
      xfer(1, mspsel_pkg::TFUNC5_OFF, 32'h00000005);
      repeat (6) @(posedge hclk);
      chk({16'h0, fv(11)}, {16'h0, target_freq});
      xfer(0, mspsel_pkg::TFUNC5_OFF, 32'h0);
      chk(32'h00000005, rv);
      xfer(1, mspsel_pkg::TFUNC5_OFF, 32'h0);
      repeat (6) @(posedge hclk);
      $display("subset test done");
   endtask

   task automatic t_store();
      xfer(1, mspsel_pkg::LIVE_OFF, 32'h00000abc);
      xfer(1, mspsel_pkg::STORE_OFF, 32'h0def0033);
      xfer(0, mspsel_pkg::PRESET_OFF + 12'h00c, 32'h0);
      chk({16'h0, fv(3)}, rv);
      xfer(1, mspsel_pkg::CTRL_OFF, 32'h00000200);
      xfer(1, mspsel_pkg::STORE_OFF, 32'h00000002);
      xfer(0, mspsel_pkg::PRESET_OFF + 12'h00c, 32'h0);
      chk(32'h00000abc, rv);
      xfer(0, mspsel_pkg::LIVE_OFF, 32'h0);
      chk(32'h00000abc, rv);
      $display("store test done");
   endtask

   task automatic t_limit();
      xfer(1, mspsel_pkg::TFUNC_OFF, 32'h03040205);
      xfer(1, mspsel_pkg::CTRL_OFF, 32'h00000201);
      xfer(1, mspsel_pkg::MAXF_OFF, 32'h00000800);
      want <= pins(4'hf);
      repeat (6) @(posedge hclk);
      chk(32'h0800, {16'h0, target_freq});
      xfer(1, mspsel_pkg::CTRL_OFF, 32'h00000101);
      xfer(0, mspsel_pkg::STATUS_OFF, 32'h0);
      chk(32'h0, rv >> 5);
      chk(32'h0, {31'h0, preset_active});
      $display("limit test done");
   endtask

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      want = 5'h00;
      output_freq_in = 16'h0000;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_presets();
      t_select();
      t_subset();
      t_store();
      t_limit();
      end_sim();
   end
endmodule // tb_top
